// ### rtl/card_port_defines.svh
`ifndef CARD_PORT_DEFINES_SVH
`define CARD_PORT_DEFINES_SVH
// register byte offsets
`define A_CTRL 8'h00
`define A_DIV 8'h04
`define A_ETU 8'h08
`define A_TXD 8'h0c
`define A_RXD 8'h10
`define A_STAT 8'h14
`define A_IST 8'h18
`define A_IEN 8'h1c
`define A_ICLR 8'h20
// control bits
`define C_CLK 0
`define C_AUTO 1
`define C_FORCE 2
`define C_RST 3
`define C_VCC 4
// status register bits
`define S_BUSY 6
`define S_PD 7
`define S_IOLOW 8
// interrupt bits
`define I_INS 0
`define I_REM 1
`define I_RX 2
`define I_PD 3
`define I_W 4
// reset values
`define DIV_RST 8'h03
`define ETU_RST 16'h0ba0
// fifo depth and frame lengths
`define FIFO_D 3'h4
`define TX_LAST 4'ha
`define RX_LAST 4'h9
// power-down step time
`define CLK_NS 8
`define PD_STEP_NS 1000
`define PD_STEP_CYC 8'((`PD_STEP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### rtl/scp_pkg.sv
package scp_pkg;
  typedef enum logic [2:0] {PD_IDLE = 3'h0, PD_RST = 3'h1, PD_CLK = 3'h2, PD_IO = 3'h3} pd_state_t;
  typedef enum logic {TX_IDLE = 1'h0, TX_SEND = 1'h1} tx_state_t;
  typedef enum logic {RX_IDLE = 1'h0, RX_RUN = 1'h1} rx_state_t;
  typedef struct packed {
    logic [7:0] ccnt;
    logic cclk;
    logic [15:0] ecnt;
    logic tick;
    logic mid;
  } cg_t;
  typedef struct packed {
    logic [1:0] pd_sync;
    logic pd_q;
    logic [1:0] io_sync;
    logic io_q;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic clk_en;
    logic auto_pd;
    logic rst_rel;
    logic supply;
    logic io_low;
    logic io_oe;
    logic io_o;
    logic pull;
    logic [7:0] div;
    logic [15:0] etu;
    logic [3:0] ist;
    logic [3:0] ien;
    logic irq;
    pd_state_t pst;
    logic [7:0] pcnt;
    logic [3:0][7:0] txf;
    logic [2:0] txc;
    logic [3:0][7:0] rxf;
    logic [2:0] rxc;
    tx_state_t tst;
    logic [10:0] tsh;
    logic [3:0] tbit;
    rx_state_t rxs;
    logic [9:0] rsh;
    logic [3:0] rbit;
  } st_t;
endpackage

// ### rtl/sim_card_clkgen.sv
`timescale 1ns/100ps
`include "card_port_defines.svh"
module sim_card_clkgen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clk_en,
  input wire logic [7:0] div,
  input wire logic [15:0] etu,
  input wire logic etu_restart,
  // generated clocks
  output logic card_clk,
  output logic clk_low,
  output logic etu_tick,
  output logic etu_mid
);
  scp_pkg::cg_t s, n;

  ////////////////////////////////////////////////////////////
  // card clock divider and bit-period timer
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.mid = 1'b0;
    // a stopped clock always finishes its high half first
    if (clk_en || s.cclk) begin
      if (s.ccnt >= div) begin // a lowered divider must not wait for a counter wrap
        n.ccnt = 8'h00;
        n.cclk = ~s.cclk;
      end else begin
        n.ccnt = s.ccnt + 8'h01;
      end
    end else begin
      n.ccnt = 8'h00;
    end
    // bit timer restarts on each frame start edge
    if (etu_restart) begin
      n.ecnt = 16'h0000;
    end else if (s.ecnt >= 16'(etu - 16'h0001)) begin
      n.ecnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.ecnt = s.ecnt + 16'h0001;
    end
    n.mid = !etu_restart && (s.ecnt == {1'b0, etu[15:1]});
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign card_clk = s.cclk;
  assign clk_low = ~s.cclk & ~clk_en;
  assign etu_tick = s.tick;
  assign etu_mid = s.mid;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CLK_STOP_LOW: assert property (!clk_en && !card_clk |=> !card_clk)
    else $error("card clock restarted while disabled");
  AST_CLK_HALF: assert property (clk_en && $rose(card_clk) && div == 8'h01 && $stable(div) |-> card_clk [*2])
    else $error("card clock half period wrong");
endmodule

// ### rtl/sim_card_port_control.sv
`timescale 1ns/100ps
`include "card_port_defines.svh"
// Operation
// - power-down drops reset, stops clock low, drives io low, then removes supply
// - presence edges set flags that raise a maskable interrupt
// - presence input has an internal pull-up, so removal gives a falling edge
// - forced power-down runs the same sequence without auto enable or presence event
// - supply must be off before the removed card loses contact
// - one clock generator makes the internal timing and the card clock
// - the clock generator raises no interrupt
// - transmit path has a state machine, shift register and fifo
// - receive path has a state machine, fifo and control logic
// - processor reaches the port through a 32-bit register interface with 16 data bits
module sim_card_port_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card pins
  output logic card_rst_n,
  output logic card_clk,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe,
  input wire logic card_presence_detect,
  output logic card_presence_pullup_en,
  output logic card_supply_enable_pin,
  // interrupt
  output logic irq
);
  scp_pkg::st_t s, n;
  logic setup, acc, wr, rd, ev_ins, ev_rem, ctrl_wr, pd_go, tx_start, rx_start;
  logic tx_push, rx_pop, rx_last, rx_ok, clk_low, tick, mid;
  logic [9:0] rx_word;

  ////////////////////////////////////////////////////////////
  // register read mux, 16 data bits, upper half reads zero
  function automatic logic [31:0] rd_mux(input scp_pkg::st_t st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `A_CTRL: begin
        r[`C_CLK] = st.clk_en;
        r[`C_AUTO] = st.auto_pd;
        r[`C_RST] = st.rst_rel;
        r[`C_VCC] = st.supply;
      end
      `A_DIV: r[7:0] = st.div;
      `A_ETU: r[15:0] = st.etu;
      `A_RXD: r[7:0] = st.rxf[0];
      `A_STAT: begin
        r[5:0] = {st.rxc, st.txc};
        r[`S_BUSY] = st.pst != scp_pkg::PD_IDLE;
        r[`S_PD] = st.pd_sync[1];
        r[`S_IOLOW] = st.io_low;
      end
      `A_IST: r[`I_W-1:0] = st.ist;
      `A_IEN: r[`I_W-1:0] = st.ien;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // decoded addresses
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      `A_CTRL, `A_DIV, `A_ETU, `A_TXD, `A_RXD, `A_STAT, `A_IST, `A_IEN, `A_ICLR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////
  // bus phases and events
  assign setup = psel & ~penable;
  assign acc = psel & penable & s.pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  // falling presence level is a removal thanks to the pull-up
  assign ev_ins = s.pd_sync[1] & ~s.pd_q;
  assign ev_rem = ~s.pd_sync[1] & s.pd_q;
  assign ctrl_wr = wr && (paddr == `A_CTRL);
  // force bit, a supply-off write or an auto removal start power-down
  assign pd_go = (s.pst == scp_pkg::PD_IDLE) && ((ctrl_wr && pwdata[`C_FORCE])
    || (ctrl_wr && s.supply && !pwdata[`C_VCC]) || (ev_rem && s.auto_pd && s.supply));
  assign tx_push = wr && (paddr == `A_TXD) && (s.txc < `FIFO_D);
  assign rx_pop = rd && (paddr == `A_RXD) && (s.rxc != 3'h0);
  // half duplex: a frame starts only when both directions are idle
  assign tx_start = s.tst == scp_pkg::TX_IDLE && s.rxs == scp_pkg::RX_IDLE && s.txc != 3'h0
    && s.clk_en && !s.io_low && s.pst == scp_pkg::PD_IDLE;
  assign rx_start = s.rxs == scp_pkg::RX_IDLE && s.tst == scp_pkg::TX_IDLE && !tx_start
    && s.io_q && !s.io_sync[1] && s.clk_en && !s.io_low;
  assign rx_last = s.rxs == scp_pkg::RX_RUN && mid && s.rbit == `RX_LAST;
  assign rx_word = {s.io_sync[1], s.rsh[9:1]};
  // start bit low and even parity over data and parity bit
  assign rx_ok = rx_last && !rx_word[0] && !(^rx_word[9:1]);

  ////////////////////////////////////////////////////////////
  // card clock and bit timing, no interrupt leaves this block
  sim_card_clkgen u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(s.clk_en),
    .div(s.div),
    .etu(s.etu),
    .etu_restart(tx_start | rx_start),
    .card_clk(card_clk),
    .clk_low(clk_low),
    .etu_tick(tick),
    .etu_mid(mid)
  );

  ////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [3:0] set;
    set = 4'h0;
    n = s;
    // two-stage synchronisers
    n.pd_sync = {s.pd_sync[0], card_presence_detect};
    n.pd_q = s.pd_sync[1];
    n.io_sync = {s.io_sync[0], card_io_in};
    n.io_q = s.io_sync[1];
    // apb answers in the first access cycle
    n.pready = setup;
    n.pslverr = setup && !addr_hit(paddr);
    n.prdata = setup ? rd_mux(s, paddr) : 32'h0000_0000;
    if (wr && paddr == `A_DIV) begin
      n.div = pwdata[7:0];
    end
    if (wr && paddr == `A_ETU) begin
      n.etu = pwdata[15:0];
    end
    if (wr && paddr == `A_IEN) begin
      n.ien = pwdata[`I_W-1:0];
    end
    // power-down sequencer, one step time between steps
    case (s.pst)
      scp_pkg::PD_IDLE: begin
        if (pd_go) begin
          n.rst_rel = 1'b0;
          n.auto_pd = ctrl_wr ? pwdata[`C_AUTO] : s.auto_pd;
          n.pcnt = `PD_STEP_CYC;
          n.pst = scp_pkg::PD_RST;
        end else if (ctrl_wr) begin
          // software power-up: supply, clock enable and reset release all load from the write in one cycle
          n.clk_en = pwdata[`C_CLK];
          n.auto_pd = pwdata[`C_AUTO];
          n.rst_rel = pwdata[`C_RST];
          n.supply = pwdata[`C_VCC];
          if (pwdata[`C_VCC]) begin
            n.io_low = 1'b0;
          end
        end
      end
      scp_pkg::PD_RST: begin
        if (s.pcnt != 8'h00) begin
          n.pcnt = s.pcnt - 8'h01;
        end else begin
          n.clk_en = 1'b0;
          n.pcnt = `PD_STEP_CYC;
          n.pst = scp_pkg::PD_CLK;
        end
      end
      scp_pkg::PD_CLK: begin
        if (s.pcnt != 8'h00) begin
          n.pcnt = s.pcnt - 8'h01;
        end else if (clk_low) begin
          // clock parked low; abort any frame and pull io low
          n.io_low = 1'b1;
          n.tst = scp_pkg::TX_IDLE;
          n.rxs = scp_pkg::RX_IDLE;
          n.pcnt = `PD_STEP_CYC;
          n.pst = scp_pkg::PD_IO;
        end
      end
      scp_pkg::PD_IO: begin
        if (s.pcnt != 8'h00) begin
          n.pcnt = s.pcnt - 8'h01;
        end else begin
          n.supply = 1'b0;
          set[`I_PD] = 1'b1;
          n.pst = scp_pkg::PD_IDLE;
        end
      end
      default: n.pst = scp_pkg::PD_IDLE;
    endcase
    // transmit: shift fifo feeds an 11-bit frame, lsb first
    if (tx_start) begin
      n.tsh = {1'b1, ^s.txf[0], s.txf[0], 1'b0};
      n.tbit = 4'h0;
      n.tst = scp_pkg::TX_SEND;
      for (int i = 0; i < 3; i++) begin
        n.txf[i] = s.txf[i+1];
      end
      n.txc = s.txc - 3'h1;
    end else if (s.tst == scp_pkg::TX_SEND && tick && s.pst != scp_pkg::PD_IO) begin
      n.tsh = {1'b1, s.tsh[10:1]};
      n.tbit = s.tbit + 4'h1;
      if (s.tbit == `TX_LAST) begin
        n.tst = scp_pkg::TX_IDLE;
      end
    end
    if (tx_push) begin
      n.txf[n.txc[1:0]] = pwdata[7:0];
      n.txc = n.txc + 3'h1;
    end
    // receive: mid-bit samples of start, data and parity
    if (rx_start) begin
      n.rbit = 4'h0;
      n.rxs = scp_pkg::RX_RUN;
    end else if (s.rxs == scp_pkg::RX_RUN && mid && s.pst != scp_pkg::PD_IO) begin
      n.rsh = rx_word;
      n.rbit = s.rbit + 4'h1;
      if (rx_last) begin
        n.rxs = scp_pkg::RX_IDLE;
      end
    end
    if (rx_pop) begin
      for (int i = 0; i < 3; i++) begin
        n.rxf[i] = s.rxf[i+1];
      end
      n.rxc = s.rxc - 3'h1;
    end
    // a full fifo drops the word but still flags it
    if (rx_ok) begin
      set[`I_RX] = 1'b1;
      if (n.rxc < `FIFO_D) begin
        n.rxf[n.rxc[1:0]] = rx_word[8:1];
        n.rxc = n.rxc + 3'h1;
      end
    end
    // sticky flags, a new event wins over a clear
    set[`I_INS] = ev_ins;
    set[`I_REM] = ev_rem;
    n.ist = (s.ist & ~((wr && paddr == `A_ICLR) ? pwdata[`I_W-1:0] : 4'h0)) | set;
    n.irq = |(n.ist & n.ien);
    // io is open drain: drive only zeros, or low while unpowered
    n.io_o = 1'b0;
    n.io_oe = n.io_low | (n.tst == scp_pkg::TX_SEND && !n.tsh[0]);
    n.pull = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // state register, card unpowered with io held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.io_low <= 1'b1;
      s.io_oe <= 1'b1;
      s.pull <= 1'b1;
      s.div <= `DIV_RST;
      s.etu <= `ETU_RST;
    end else begin
      s <= n;
    end
  end

  // outputs from flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign card_rst_n = s.rst_rel;
  assign card_io_out = s.io_o;
  assign card_io_oe = s.io_oe;
  assign card_presence_pullup_en = s.pull;
  assign card_supply_enable_pin = s.supply;
  assign irq = s.irq;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_APB_READY: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  AST_APB_UPPER: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_PD_RST_FIRST: assert property (pd_go |=> !card_rst_n && $stable(card_supply_enable_pin))
    else $error("reset not dropped first");
  AST_IO_AFTER_CLK: assert property ($rose(s.io_low) |-> !card_clk && !card_rst_n && card_supply_enable_pin == $past(s.supply))
    else $error("io driven low before clock stop");
  AST_VCC_LAST: assert property ($fell(card_supply_enable_pin) |-> card_io_oe && !card_io_out && !card_rst_n && !card_clk)
    else $error("supply dropped out of order");
  AST_AUTO_PD: assert property (ev_rem && s.auto_pd && s.supply && s.pst == scp_pkg::PD_IDLE |=> s.pst == scp_pkg::PD_RST)
    else $error("removal did not start power-down");
  AST_FORCE_PD: assert property (ctrl_wr && pwdata[`C_FORCE] && s.pst == scp_pkg::PD_IDLE |=> s.pst == scp_pkg::PD_RST)
    else $error("forced power-down not started");
  AST_PD_BOUND: assert property ($rose(s.pst == scp_pkg::PD_RST) |-> ##[1:1000] !card_supply_enable_pin)
    else $error("supply still on after power-down");
  AST_REM_FLAG: assert property (ev_rem |=> s.ist[`I_REM] && (s.ien[`I_REM] -> irq))
    else $error("removal flag or interrupt missing");
  AST_IRQ_MASK: assert property ((s.ist & s.ien) == 4'h0 |-> !irq)
    else $error("interrupt with all flags masked");
  AST_PULLUP: assert property (card_presence_pullup_en)
    else $error("presence pull-up off");
  AST_TX_RELEASE: assert property (s.tst == scp_pkg::TX_IDLE && !s.io_low |-> !card_io_oe)
    else $error("io driven with transmitter idle");
  AST_RX_STORE: assert property (rx_ok && s.rxc < `FIFO_D && !rx_pop |=> s.rxc == $past(s.rxc) + 3'h1)
    else $error("received word not stored");
  // power-down holds each earlier step while later ones run
  AST_RST_HELD_PD: assert property (s.pst != scp_pkg::PD_IDLE |-> !card_rst_n)
    else $error("card reset released during power-down");
  AST_CLK_LOW_PD: assert property (s.pst == scp_pkg::PD_IO |-> !card_clk)
    else $error("card clock running while io held low");
  AST_IO_LOW_PD: assert property (s.pst == scp_pkg::PD_IO |-> card_io_oe && !card_io_out)
    else $error("io not held low before supply off");
  AST_VCC_FROM_SEQ: assert property ($fell(card_supply_enable_pin) |-> $past(s.pst) == scp_pkg::PD_IO)
    else $error("supply dropped outside the sequence");
  AST_PD_FLAG: assert property (s.pst == scp_pkg::PD_IO && s.pcnt == 8'h00 |=> s.ist[`I_PD])
    else $error("power-down done flag missing");
  // bus, fifos and flags
  AST_APB_ERR: assert property (setup && !addr_hit(paddr) |=> pready && pslverr)
    else $error("unmapped access without error");
  AST_TX_PUSH: assert property (tx_push && !tx_start |=> s.txc == $past(s.txc) + 3'h1)
    else $error("written byte not queued");
  AST_TX_START_BIT: assert property (tx_start |=> card_io_oe)
    else $error("start bit not driven low");
  AST_TX_BOUND: assert property (s.txc <= `FIFO_D)
    else $error("transmit fifo count overflow");
  AST_RX_BOUND: assert property (s.rxc <= `FIFO_D)
    else $error("receive fifo count overflow");
  AST_INS_FLAG: assert property (ev_ins |=> s.ist[`I_INS])
    else $error("insertion flag missing");
  AST_IRQ_SET: assert property ((s.ist & s.ien) != 4'h0 |-> irq)
    else $error("enabled flag without interrupt");

  COV_PD_DONE: cover property (s.pst == scp_pkg::PD_IO ##1 s.pst == scp_pkg::PD_IDLE);
  COV_TX_FRAME: cover property (tx_start ##1 s.tst == scp_pkg::TX_SEND);
  COV_RX_OK: cover property (rx_ok);
  COV_REMOVAL: cover property (ev_rem && s.auto_pd && s.supply);
  COV_FORCE_PD: cover property (ctrl_wr && pwdata[`C_FORCE] && s.pst == scp_pkg::PD_IDLE);
endmodule

// ### tb/sim_card_model.sv
`timescale 1ns/100ps
module sim_card_model #(
  parameter logic supply_voltage_select = 1'b1 // set picks the higher card supply
) (
  // clock
  input wire logic pclk,
  // card pins from the port
  input wire logic card_rst_n,
  input wire logic card_clk,
  input wire logic card_io_out,
  input wire logic card_io_oe,
  input wire logic card_supply_enable_pin,
  // power chip control and link timing
  input wire logic supply_enable_bit,
  input wire logic [15:0] etu_cyc,
  // wire level and supply state
  output logic card_io_in,
  output logic vcc_on,
  output logic order_bad
);
  logic card_low = 1'b0;
  logic io_q = 1'b1;
  logic vcc_q = 1'b0;
  logic [9:0] f;
  logic [8:0] rx_q[$];
  logic bad = 1'b0;
  logic card_powered;
  // regulator runs only with pin and bit both high
  assign vcc_on = card_supply_enable_pin & supply_enable_bit;
  // a 3 V card only works with the higher supply selected
  assign card_powered = vcc_on & supply_voltage_select;
  assign order_bad = bad;
  // open drain wire with pull-up: low if either side pulls
  assign card_io_in = !((card_io_oe && !card_io_out) || card_low);
  // supply must not vanish while the card is still active
  always @(posedge pclk) begin
    vcc_q <= vcc_on;
    if (vcc_q && !vcc_on && (card_rst_n || card_clk || !card_io_oe))
      bad <= 1'b1;
  end
  // send one frame, optionally after a delay
  task automatic send_byte(input logic [7:0] d, input int gap);
    logic [10:0] fr;
    fr = {1'b1, ^d, d, 1'b0};
    repeat (gap) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      card_low <= ~fr[i] & card_powered;
      repeat (etu_cyc) @(posedge pclk);
    end
    card_low <= 1'b0;
  endtask
  // decode frames from the port, storing frame-ok and data
  always begin
    @(posedge pclk);
    if (io_q && !card_io_in && card_powered && card_rst_n && !card_low) begin
      for (int k = 0; k < 10; k++) begin
        repeat ((k == 0) ? etu_cyc + etu_cyc / 2 : etu_cyc) @(posedge pclk);
        f[k] = card_io_in;
      end
      rx_q.push_back({(f[8] == ^f[7:0]) && f[9], f[7:0]});
    end
    io_q = card_io_in;
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
`include "card_port_defines.svh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, b;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, card_rst_n, card_clk, card_io_in, card_io_out, card_io_oe, irq;
  logic card_presence_pullup_en, card_supply_enable_pin, vcc_on, order_bad;
  logic card_presence_detect = 1, supply_enable_bit = 1;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 76623, t_rst, t_oe, t_sup, n, tg;
  logic [7:0] tx_b[5];
  always #4 pclk = ~pclk;
  sim_card_port_control i_sim_card_port_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_rst_n(card_rst_n), .card_clk(card_clk),
    .card_io_in(card_io_in), .card_io_out(card_io_out), .card_io_oe(card_io_oe),
    .card_presence_detect(card_presence_detect), .card_presence_pullup_en(card_presence_pullup_en),
    .card_supply_enable_pin(card_supply_enable_pin), .irq(irq));
  sim_card_model i_sim_card_model (.pclk(pclk), .card_rst_n(card_rst_n), .card_clk(card_clk),
    .card_io_out(card_io_out), .card_io_oe(card_io_oe), .card_supply_enable_pin(card_supply_enable_pin),
    .supply_enable_bit(supply_enable_bit), .etu_cyc(16'h0010), .card_io_in(card_io_in),
    .vcc_on(vcc_on), .order_bad(order_bad));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // card clock toggles expected over a window for a divider value
  function automatic int exp_toggles(input int cycles, input int dv);
    return cycles / (dv + 1);
  endfunction
  // one apb transfer, waiting for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    chk("pready", 1, pready);
    chk("pslverr", (a > `A_ICLR) ? 1 : 0, pslverr);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // follow a power-down and note when the reset, io and supply steps land
  task automatic wait_pd();
    t_rst = -1;
    t_oe = -1;
    t_sup = -1;
    for (int t = 0; t < 1500 && t_sup < 0; t++) begin
      @(posedge pclk);
      if (t_rst < 0 && card_rst_n === 1'b0) t_rst = t;
      if (t_oe < 0 && card_io_oe === 1'b1) t_oe = t;
      if (card_supply_enable_pin === 1'b0) t_sup = t;
    end
    chk("clk stopped low", 0, card_clk);
    chk("rst before io low", 1, t_rst >= 0 && t_rst < t_oe);
    chk("supply off last", 1, t_oe >= 0 && t_oe < t_sup);
    chk("order at supply", 0, order_bad);
  endtask
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    chk("reset card_rst_n", 0, card_rst_n);
    chk("reset supply", 0, card_supply_enable_pin);
    chk("reset io low", 1, card_io_oe);
    chk("pull-up", 1, card_presence_pullup_en);
    presetn <= 1;
    rdc("div reset", `A_DIV, {24'h0, `DIV_RST});
    rdc("etu reset", `A_ETU, {16'h0, `ETU_RST});
    rdc("unmapped", 8'h24, 32'h0);
    apb(1, `A_ETU, 32'hffff0010);
    rdc("etu 16 bits", `A_ETU, 32'h10);
    apb(1, `A_IEN, 32'hf);
    apb(1, `A_ICLR, 32'hf);
    // software power-up
    apb(1, `A_CTRL, 32'h19);
    // pins change at the write edge, look one edge later
    @(posedge pclk);
    chk("supply on", 1, vcc_on);
    chk("card_rst_n up", 1, card_rst_n);
    tg = 0;
    n = 0;
    for (int i = 0; i < 80; i++) begin
      b[0] = card_clk;
      @(posedge pclk);
      tg += (card_clk !== b[0]);
      n += (irq !== 1'b0);
    end
    chk("clk toggles", 1, tg >= exp_toggles(80, `DIV_RST) - 1 && tg <= exp_toggles(80, `DIV_RST) + 1);
    chk("no clock irq", 0, n);
    // a faster divider while the clock runs
    apb(1, `A_DIV, 32'h1);
    tg = 0;
    for (int i = 0; i < 80; i++) begin
      b[0] = card_clk;
      @(posedge pclk);
      tg += (card_clk !== b[0]);
    end
    chk("clk toggles fast", 1, tg >= exp_toggles(80, 1) - 1 && tg <= exp_toggles(80, 1) + 1);
    apb(1, `A_DIV, {24'h0, `DIV_RST});
    // fill the tx fifo with the clock stopped, then release
    apb(1, `A_CTRL, 32'h18);
    i_sim_card_model.rx_q.delete();
    for (int i = 0; i < 5; i++) begin
      tx_b[i] = 8'($random(seed));
      apb(1, `A_TXD, {24'h0, tx_b[i]});
    end
    apb(0, `A_STAT, 32'h0);
    chk("tx count", {29'h0, `FIFO_D}, {29'h0, rd[2:0]});
    apb(1, `A_CTRL, 32'h19);
    n = 0;
    while (i_sim_card_model.rx_q.size() < 4 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    for (int i = 0; i < 4; i++)
      chk("tx frame", {23'h0, 1'b1, tx_b[i]}, {23'h0, i_sim_card_model.rx_q[i]});
    // let the last stop bit end before the card answers
    repeat (40) @(posedge pclk);
    // receive bytes, last one with the interrupt masked
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      apb(1, `A_IEN, (i == 2) ? 32'h0 : 32'hf);
      i_sim_card_model.send_byte(b, i * 5);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge pclk);
        n++;
      end
      chk("rx irq", (i == 2) ? 0 : 1, irq);
      rdc("rx flag", `A_IST, 32'h1 << `I_RX);
      rdc("rx data", `A_RXD, {24'h0, b});
      apb(1, `A_ICLR, 32'hf);
    end
    // removal with auto power-down
    apb(1, `A_IEN, 32'hf);
    apb(1, `A_CTRL, 32'h1b);
    card_presence_detect <= 0;
    wait_pd();
    rdc("removal flags", `A_IST, (32'h1 << `I_REM) | (32'h1 << `I_PD));
    card_presence_detect <= 1;
    repeat (10) @(posedge pclk);
    rdc("insert flag", `A_IST, 32'h1 << `I_INS | (32'h1 << `I_REM) | (32'h1 << `I_PD));
    // forced power-down without auto or presence event
    apb(1, `A_ICLR, 32'hf);
    apb(1, `A_CTRL, 32'h19);
    repeat (20) @(posedge pclk);
    apb(1, `A_CTRL, 32'h1d);
    wait_pd();
    rdc("forced flags", `A_IST, 32'h1 << `I_PD);
    chk("pd irq", 1, irq);
    // writing the supply bit low runs the same sequence
    apb(1, `A_ICLR, 32'hf);
    apb(1, `A_CTRL, 32'h19);
    repeat (20) @(posedge pclk);
    apb(1, `A_CTRL, 32'h09);
    wait_pd();
    rdc("supply-off flags", `A_IST, 32'h1 << `I_PD);
    finish_test();
  end
endmodule
